// *** design/pcx_pkg.sv ***
`default_nettype none
package pcx_pkg;
  localparam int unsigned ADDR_W  = 24;
  localparam int unsigned NUM_CH  = 32;
  localparam int unsigned CH_W    = 5;
  localparam int unsigned XA_W    = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned RADDR_W = 4;

  // operation codes (g and h fields together)
  localparam logic [6:0] OP_ERR_EXIT = 7'h00;
  localparam logic [6:0] OP_CHAN     = 7'h01;
  // i field selects the channel operation
  localparam logic [2:0] SUB_SET_CA  = 3'h0;
  localparam logic [2:0] SUB_SET_CL  = 3'h1;
  localparam logic [2:0] SUB_CLR     = 3'h2;
  localparam logic [2:0] FIELD_ZERO  = 3'h0;
  localparam logic [2:0] K_MCLR      = 3'h1;

  // legal channel numbers and special values
  localparam logic [ADDR_W-1:0] CH_LOW      = 24'h000002;
  localparam logic [ADDR_W-1:0] CH_HIGH     = 24'h000019;
  localparam logic [ADDR_W-1:0] ONE_VAL     = 24'h000001;
  localparam logic [ADDR_W-1:0] PARCEL_STEP = 24'h000001;

  // software register indices and reset values
  localparam logic [RADDR_W-1:0] REG_XA       = 4'h0;
  localparam logic [RADDR_W-1:0] REG_DIR      = 4'h1;
  localparam logic [RADDR_W-1:0] REG_STATUS   = 4'h2;
  localparam logic [RADDR_W-1:0] REG_SAVED_PA = 4'h3;
  localparam logic [XA_W-1:0]    XA_RESET     = 8'h00;
  localparam logic [NUM_CH-1:0]  DIR_RESET    = 32'h00000000;

  typedef struct packed {
    logic [3:0] g;
    logic [2:0] h;
    logic [2:0] i;
    logic [2:0] j;
    logic [2:0] k;
  } pcx_parcel_type;

  typedef struct packed {
    logic              wr_ca;
    logic              wr_cl;
    logic              clr_flags;
    logic [CH_W-1:0]   num;
    logic [ADDR_W-1:0] value;
  } pcx_chan_cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRAIN = 2'b01,
    ST_XCHG  = 2'b10
  } pcx_state_type;

  // one bit per channel, used for set and clear masks
  function automatic logic [NUM_CH-1:0] ch_onehot(input logic [CH_W-1:0] n);
    logic [NUM_CH-1:0] m;
    m = '0;
    m[n] = 1'b1;
    return m;
  endfunction
endpackage
`default_nettype wire

// *** design/pcx_chan_bank.sv ***
`default_nettype none
module pcx_chan_bank (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire pcx_pkg::pcx_chan_cmd_type cmd,
  input  wire logic                     step_valid,
  input  wire logic [4:0]               step_num,
  input  wire logic [31:0]              intr_set,
  input  wire logic [31:0]              err_set,
  output logic [31:0]                   active_reg,
  output logic [31:0]                   intr_reg,
  output logic [31:0]                   err_reg,
  output logic                          start_reg,
  output logic [4:0]                    start_num_reg,
  output logic                          done_reg,
  output logic [23:0]                   word_addr_reg
);
  import pcx_pkg::*;

  logic [ADDR_W-1:0] ca_reg [NUM_CH];
  logic [ADDR_W-1:0] cl_reg [NUM_CH];
  logic [ADDR_W-1:0] ca_next;
  logic              step_go;
  logic              step_last;
  logic [NUM_CH-1:0] clr_mask;

  // a word moves only while active and short of the limit
  assign ca_next   = ca_reg[step_num] + PARCEL_STEP;
  assign step_go   = step_valid && active_reg[step_num] &&
                     (ca_reg[step_num] != cl_reg[step_num]);
  assign step_last = step_go && (ca_next == cl_reg[step_num]);
  assign clr_mask  = cmd.clr_flags ? ch_onehot(cmd.num) : '0;

  // address arrays hold data only, so they carry no reset
  always_ff @(posedge clk) begin
    if (step_go) begin
      ca_reg[step_num] <= ca_next;
    end
    if (cmd.wr_ca) begin
      ca_reg[cmd.num] <= cmd.value;
    end
    if (cmd.wr_cl) begin
      cl_reg[cmd.num] <= cmd.value;
    end
  end

  // activity, start strobe and end of transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg    <= '0;
      start_reg     <= 1'b0;
      start_num_reg <= '0;
      done_reg      <= 1'b0;
      word_addr_reg <= '0;
    end else begin
      active_reg <= (active_reg & ~(step_last ? ch_onehot(step_num) : '0)) |
                    (cmd.wr_ca ? ch_onehot(cmd.num) : '0);
      start_reg     <= cmd.wr_ca;
      start_num_reg <= cmd.wr_ca ? cmd.num : start_num_reg;
      done_reg      <= step_last;
      if (step_go) begin
        word_addr_reg <= ca_reg[step_num];
      end
    end
  end

  // channel flags: a set in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      intr_reg <= '0;
      err_reg  <= '0;
    end else begin
      intr_reg <= (intr_reg & ~clr_mask) | intr_set;
      err_reg  <= (err_reg & ~clr_mask) | err_set;
    end
  end
endmodule
`default_nettype wire

// *** design/pcx_chan_exit_unit.sv ***
// Decided for this implementation: the register addresses and strobed register access.
`default_nettype none
// Functional notes
// - user mode makes privileged ops no-ops
// - opcode zero exchanges, voiding instruction buffers
// - error flag set only outside monitor
// - drain issued work, then exchange to XA
// - saved address is own address plus one
// - error exit ignores i, j, k
// - 0010jk loads current address, activates channel
// - address steps per word, ends at limit
// - user mode, j zero, bad channel pass
// - k zero loads current address with one
// - 0011jk loads limit, no activation
// - k zero loads limit with one
// - 0012j0 clears interrupt and error flags
// - 0012j1 also master-clear or ready-clear
// - ignored fields never change execution
// - parcel is g4, h3, i3, j3, k3
module pcx_chan_exit_unit (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   instr_valid,
  input  wire pcx_pkg::pcx_parcel_type instr,
  input  wire logic [23:0]            instr_pa,
  input  wire logic                   monitor_mode,
  input  wire logic [23:0]            aj_val,
  input  wire logic [23:0]            ak_val,
  input  wire logic                   pipe_idle,
  input  wire logic                   xchg_ack,
  input  wire logic                   chan_step_valid,
  input  wire logic [4:0]             chan_step_num,
  input  wire logic [31:0]            chan_intr_set,
  input  wire logic [31:0]            chan_err_set,
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  output logic                        instr_ready,
  output logic                        instr_done,
  output logic                        xchg_req,
  output logic [7:0]                  xchg_addr,
  output logic [23:0]                 xchg_pa,
  output logic                        ibuf_invalidate,
  output logic                        err_exit_flag_set,
  output logic                        dev_master_clear,
  output logic                        dev_ready_clear,
  output logic [4:0]                  dev_num,
  output logic                        ch_start,
  output logic [4:0]                  ch_start_num,
  output logic                        ch_done,
  output logic [23:0]                 ch_word_addr,
  output logic [31:0]                 ch_active,
  output logic [31:0]                 ch_intr_flags,
  output logic [31:0]                 ch_err_flags
);
  import pcx_pkg::*;

  // privilege, j field and channel range in one check
  function automatic logic chan_allowed(input logic            mm,
                                        input logic [2:0]      j,
                                        input logic [ADDR_W-1:0] a);
    return mm && (j != FIELD_ZERO) && (a >= CH_LOW) && (a <= CH_HIGH);
  endfunction

  pcx_state_type     state_reg;
  pcx_chan_cmd_type  cmd_reg;
  pcx_chan_cmd_type  cmd_next;
  logic              ready_reg;
  logic              done_reg;
  logic              xchg_req_reg;
  logic [XA_W-1:0]   xchg_addr_reg;
  logic [ADDR_W-1:0] saved_pa_reg;
  logic              ibuf_inv_reg;
  logic              err_flag_reg;
  logic              mclr_reg;
  logic              rclr_reg;
  logic [CH_W-1:0]   dev_num_reg;
  logic [XA_W-1:0]   xa_reg;
  logic [NUM_CH-1:0] dir_reg;
  logic [DATA_W-1:0] rdata_reg;

  logic [6:0]        opcode;
  logic              accept;
  logic              is_err;
  logic              is_chan;
  logic              chan_ok;
  logic              do_mclr;
  logic [ADDR_W-1:0] value_sel;
  logic [CH_W-1:0]   sel_num;

  assign opcode  = {instr.g, instr.h};
  assign accept  = instr_valid && ready_reg;
  // ignored fields kept out of decode
  // error exit decodes on gh only
  assign is_err  = accept && (opcode == OP_ERR_EXIT);
  assign is_chan = accept && (opcode == OP_CHAN) && (instr.i <= SUB_CLR);
  assign chan_ok = is_chan && chan_allowed(monitor_mode, instr.j, aj_val);
  assign sel_num = aj_val[CH_W-1:0];
  assign do_mclr = chan_ok && (instr.i == SUB_CLR) && (instr.k == K_MCLR);
  assign value_sel = (instr.k == FIELD_ZERO) ? ONE_VAL : ak_val;

  // channel command built in the decode cycle
  always_comb begin
    cmd_next = '0;
    if (chan_ok) begin
      cmd_next.num       = sel_num;
      cmd_next.value     = value_sel;
      cmd_next.wr_ca     = (instr.i == SUB_SET_CA);
      cmd_next.wr_cl     = (instr.i == SUB_SET_CL);
      cmd_next.clr_flags = (instr.i == SUB_CLR);
    end
  end

  // command register feeding the channel bank
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // device-side clears; direction comes from software map
  always_ff @(posedge clk) begin
    if (rst) begin
      mclr_reg    <= 1'b0;
      rclr_reg    <= 1'b0;
      dev_num_reg <= '0;
    end else begin
      mclr_reg <= do_mclr && dir_reg[sel_num];
      rclr_reg <= do_mclr && !dir_reg[sel_num];
      if (do_mclr) begin
        dev_num_reg <= sel_num;
      end
    end
  end

  // error exit sequencer; only one instruction is taken at a time
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      ready_reg     <= 1'b1;
      xchg_req_reg  <= 1'b0;
      xchg_addr_reg <= XA_RESET;
      saved_pa_reg  <= '0;
      ibuf_inv_reg  <= 1'b0;
      err_flag_reg  <= 1'b0;
    end else begin
      ibuf_inv_reg <= 1'b0;
      err_flag_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (is_err) begin
            state_reg    <= ST_DRAIN;
            ready_reg    <= 1'b0;
            saved_pa_reg <= instr_pa + PARCEL_STEP;
            err_flag_reg <= !monitor_mode;
          end
        end
        ST_DRAIN: begin
          if (pipe_idle) begin
            state_reg     <= ST_XCHG;
            xchg_req_reg  <= 1'b1;
            xchg_addr_reg <= xa_reg;
            ibuf_inv_reg  <= 1'b1;
          end
        end
        ST_XCHG: begin
          if (xchg_ack) begin
            state_reg    <= ST_IDLE;
            ready_reg    <= 1'b1;
            xchg_req_reg <= 1'b0;
          end
        end
        default: begin
          state_reg    <= ST_IDLE;
          ready_reg    <= 1'b1;
          xchg_req_reg <= 1'b0;
        end
      endcase
    end
  end

  // completion pulse: passes finish too, so the issue stage stalls only during an error exit
  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (accept && !is_err) ||
                  ((state_reg == ST_XCHG) && xchg_ack);
    end
  end

  // software registers: exchange address and channel direction map
  always_ff @(posedge clk) begin
    if (rst) begin
      xa_reg  <= XA_RESET;
      dir_reg <= DIR_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_XA:  xa_reg  <= reg_wdata[XA_W-1:0];
        REG_DIR: dir_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= '0;
      if (reg_rd) begin
        case (reg_addr)
          REG_XA:       rdata_reg <= {{(DATA_W-XA_W){1'b0}}, xa_reg};
          REG_DIR:      rdata_reg <= dir_reg;
          REG_STATUS:   rdata_reg <= {28'h0000000, xchg_req_reg, ready_reg,
                                      state_reg};
          REG_SAVED_PA: rdata_reg <= {8'h00, saved_pa_reg};
          default:      rdata_reg <= '0;
        endcase
      end
    end
  end

  // channel address registers, flags and transfer stepping
  pcx_chan_bank u_bank (
    .clk           (clk),
    .rst           (rst),
    .cmd           (cmd_reg),
    .step_valid    (chan_step_valid),
    .step_num      (chan_step_num),
    .intr_set      (chan_intr_set),
    .err_set       (chan_err_set),
    .active_reg    (ch_active),
    .intr_reg      (ch_intr_flags),
    .err_reg       (ch_err_flags),
    .start_reg     (ch_start),
    .start_num_reg (ch_start_num),
    .done_reg      (ch_done),
    .word_addr_reg (ch_word_addr)
  );

  assign reg_rdata         = rdata_reg;
  assign instr_ready       = ready_reg;
  assign instr_done        = done_reg;
  assign xchg_req          = xchg_req_reg;
  assign xchg_addr         = xchg_addr_reg;
  assign xchg_pa           = saved_pa_reg;
  assign ibuf_invalidate   = ibuf_inv_reg;
  assign err_exit_flag_set = err_flag_reg;
  assign dev_master_clear  = mclr_reg;
  assign dev_ready_clear   = rclr_reg;
  assign dev_num           = dev_num_reg;

  // checks on the decode and exchange behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_err_accept;
    is_err;
  endsequence

  sequence s_exit_begin;
    (state_reg == ST_DRAIN) && pipe_idle;
  endsequence

  property p_pass_user;
    (is_chan && !monitor_mode) |=>
      (cmd_reg == '0) && !dev_master_clear && !dev_ready_clear;
  endproperty
  a_pass_user: assert property (p_pass_user)
    else $error("privileged op acted outside monitor mode");

  property p_range_pass;
    (is_chan && !chan_allowed(monitor_mode, instr.j, aj_val)) |=>
      (cmd_reg == '0) ##1 !ch_start;
  endproperty
  a_range_pass: assert property (p_range_pass)
    else $error("bad channel select reached the channel bank");

  property p_xchg_inval;
    s_exit_begin |=> xchg_req && ibuf_invalidate ##1 !ibuf_invalidate;
  endproperty
  a_xchg_inval: assert property (p_xchg_inval)
    else $error("exchange began without one buffer invalidate");

  property p_flag_user;
    (s_err_accept ##0 !monitor_mode) |=> err_exit_flag_set ##1 !err_exit_flag_set;
  endproperty
  a_flag_user: assert property (p_flag_user)
    else $error("error exit flag not pulsed in user mode");

  property p_flag_mon;
    (s_err_accept ##0 monitor_mode) |=> !err_exit_flag_set;
  endproperty
  a_flag_mon: assert property (p_flag_mon)
    else $error("error exit flag set in monitor mode");

  property p_drain;
    ((state_reg == ST_DRAIN) && !pipe_idle) |=> !xchg_req && !ibuf_invalidate;
  endproperty
  a_drain: assert property (p_drain)
    else $error("exchange started before issued work drained");

  property p_saved_pa;
    s_err_accept |=> (xchg_pa == $past(instr_pa) + PARCEL_STEP) && !instr_ready;
  endproperty
  a_saved_pa: assert property (p_saved_pa)
    else $error("saved program address is not next parcel");

  property p_k_zero_one;
    (chan_ok && (instr.i != SUB_CLR) && (instr.k == FIELD_ZERO)) |=>
      (cmd_reg.value == ONE_VAL);
  endproperty
  a_k_zero_one: assert property (p_k_zero_one)
    else $error("k zero did not load the value one");

  property p_start_after_ca;
    (chan_ok && (instr.i == SUB_SET_CA)) |=>
      cmd_reg.wr_ca ##1 (ch_start && (ch_start_num == $past(cmd_reg.num)));
  endproperty
  a_start_after_ca: assert property (p_start_after_ca)
    else $error("channel start strobe missing after address load");

  property p_mclr_one;
    do_mclr |=> (dev_master_clear != dev_ready_clear) && (dev_num == $past(sel_num));
  endproperty
  a_mclr_one: assert property (p_mclr_one)
    else $error("master clear op gave wrong device clear");
endmodule
`default_nettype wire

// *** design/pcx_chan_exit_unit_unused_guard.sv ***
`default_nettype none
`default_nettype wire

// *** verification/pcx_chan_partner.sv ***
`default_nettype none
module pcx_chan_partner (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        ch_start,
  input  wire logic [4:0]  ch_start_num,
  input  wire logic [31:0] ch_active,
  input  wire logic        xchg_req,
  output logic             chan_step_valid,
  output logic [4:0]       chan_step_num,
  output logic             xchg_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cur_reg;
  logic       tick_reg;
  logic [3:0] wait_reg;
  logic [4:0] sel;
  logic       go;
  // a fresh start wins over the channel remembered
  assign sel = ch_start ? ch_start_num : cur_reg;
  assign go  = ch_active[sel] && (!slow || tick_reg);
  // one word a cycle, or every other when slow; idle number flips so stale values show
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg <= 5'h00;
      tick_reg <= 1'b0;
      chan_step_valid <= 1'b0;
      chan_step_num <= 5'h00;
    end else begin
      cur_reg <= sel;
      tick_reg <= ~tick_reg;
      chan_step_valid <= go;
      chan_step_num <= go ? sel : ~chan_step_num;
    end
  end
  // exchange engine answers once, ack_delay cycles into the request
  always_ff @(posedge clk) begin
    if (rst || !xchg_req) begin
      wait_reg <= 4'h0;
      xchg_ack <= 1'b0;
    end else begin
      if (wait_reg != ack_delay) wait_reg <= wait_reg + 4'h1;
      xchg_ack <= (wait_reg == ack_delay) && !xchg_ack;
    end
  end
endmodule
`default_nettype wire

// *** verification/privileged_channel_and_error_exit_tb_top.sv ***
`default_nettype none
module privileged_channel_and_error_exit_tb_top;
  import pcx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clk, rst, instr_valid, monitor_mode, pipe_idle, reg_wr, reg_rd, slow;
  logic           chan_step_valid, xchg_ack, instr_ready, instr_done, xchg_req, ibuf_invalidate;
  logic           err_exit_flag_set, dev_master_clear, dev_ready_clear, ch_start, ch_done;
  logic [3:0]     reg_addr, ack_delay;
  logic [4:0]     chan_step_num, dev_num, ch_start_num;
  logic [7:0]     xchg_addr, xa_m;
  logic [23:0]    instr_pa, aj_val, ak_val, xchg_pa, ch_word_addr, base;
  logic [31:0]    chan_intr_set, chan_err_set, reg_wdata, reg_rdata;
  logic [31:0]    ch_active, ch_intr_flags, ch_err_flags, last_word, last_num, last_dev, last_xa;
  pcx_parcel_type instr;
  logic           prev_req;
  int             mismatches, total_checks, cycles, ln;
  int             n_done, n_start, n_mclr, n_rclr, n_errf, n_cdone, n_rise, n_bad;

  pcx_chan_exit_unit DUT (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .instr_pa(instr_pa),
    .monitor_mode(monitor_mode), .aj_val(aj_val), .ak_val(ak_val), .pipe_idle(pipe_idle),
    .xchg_ack(xchg_ack), .chan_step_valid(chan_step_valid), .chan_step_num(chan_step_num),
    .chan_intr_set(chan_intr_set), .chan_err_set(chan_err_set), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_ready(instr_ready), .instr_done(instr_done), .xchg_req(xchg_req),
    .xchg_addr(xchg_addr), .xchg_pa(xchg_pa), .ibuf_invalidate(ibuf_invalidate),
    .err_exit_flag_set(err_exit_flag_set), .dev_master_clear(dev_master_clear),
    .dev_ready_clear(dev_ready_clear), .dev_num(dev_num), .ch_start(ch_start),
    .ch_start_num(ch_start_num), .ch_done(ch_done), .ch_word_addr(ch_word_addr),
    .ch_active(ch_active), .ch_intr_flags(ch_intr_flags), .ch_err_flags(ch_err_flags));
  pcx_chan_partner far_side (
    .clk(clk), .rst(rst), .slow(slow), .ack_delay(ack_delay), .ch_start(ch_start),
    .ch_start_num(ch_start_num), .ch_active(ch_active), .xchg_req(xchg_req),
    .chan_step_valid(chan_step_valid), .chan_step_num(chan_step_num), .xchg_ack(xchg_ack));

  // free-running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // pulse tallies, taken once the edge's updates have landed
  always @(posedge clk) begin
    #1;
    if (instr_done === 1'b1) n_done++;
    if (err_exit_flag_set === 1'b1) n_errf++;
    if (dev_master_clear === 1'b1) n_mclr++;
    if (dev_ready_clear === 1'b1) n_rclr++;
    if (dev_master_clear === 1'b1 || dev_ready_clear === 1'b1) last_dev = 32'(dev_num);
    if (ch_start === 1'b1) n_start++;
    if (ch_start === 1'b1) last_num = 32'(ch_start_num);
    if (ch_done === 1'b1) n_cdone++;
    if (ch_done === 1'b1) last_word = 32'(ch_word_addr);
    if (xchg_req === 1'b1 && prev_req !== 1'b1) begin
      n_rise++;
      last_xa = 32'(xchg_addr);
      if (ibuf_invalidate !== 1'b1) n_bad++;
    end else if (ibuf_invalidate === 1'b1) n_bad++;
    // no exchange before earlier work drained, none while accepting
    if (xchg_req === 1'b1 && (pipe_idle !== 1'b1 || instr_ready !== 1'b0)) n_bad++;
    prev_req = xchg_req;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic clr();
    {n_done, n_start, n_mclr, n_rclr, n_errf, n_cdone, n_rise, n_bad} = '0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge clk);
  endtask
  // held until an edge finds the port ready; caller lowers valid
  task automatic issue(input logic [15:0] p, input logic m, input logic [23:0] pa, aj, ak);
    instr_valid <= 1'b1;
    instr <= p;
    monitor_mode <= m;
    instr_pa <= pa;
    aj_val <= aj;
    ak_val <= ak;
    do @(posedge clk); while (instr_ready !== 1'b1);
  endtask
  task automatic await(ref int c, input int want);
    for (int t = 0; t < 300 && c < want; t++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // stimulus builds only defined field combinations
  function automatic logic [15:0] chop(input logic [2:0] i, input logic [2:0] j, k);
    return {OP_CHAN, i, j, k};
  endfunction
  task automatic xfer(input logic [4:0] ch, input logic [23:0] cl, ca, input logic kl, kc);
    clr();
    issue(chop(SUB_SET_CL, 3'h3, kl ? FIELD_ZERO : 3'h4), 1'b1, 24'h0, 24'(ch),
          kl ? 24'($urandom) : cl);
    issue(chop(SUB_SET_CA, 3'h3, kc ? FIELD_ZERO : 3'h5), 1'b1, 24'h0, 24'(ch),
          kc ? 24'($urandom) : ca);
    instr_valid <= 1'b0;
    await(n_cdone, 1);
    check(n_done, 2);
    check(n_start, 1);
    check(last_num, 32'(ch));
    check(n_cdone, 1);
    check(last_word, 32'(kl ? 24'h0 : cl - 24'h1));
    check(32'(ch_active[ch]), 32'h0);
  endtask
  task automatic ctl(input logic [2:0] k, j, input logic m, out, pass, input logic [23:0] aj);
    wr(REG_DIR, out ? 32'h1 << aj[4:0] : 32'h0);
    chan_intr_set <= 32'h3 << aj[4:0];
    chan_err_set <= 32'h3 << aj[4:0];
    @(posedge clk);
    {chan_intr_set, chan_err_set} <= '0;
    clr();
    issue(chop(SUB_CLR, j, k), m, 24'h0, aj, 24'h0);
    issue(chop(pass ? SUB_SET_CA : SUB_SET_CL, j, 3'h1), m, 24'h0, aj, 24'h7);
    instr_valid <= 1'b0;
    await(n_done, 2);
    check(n_start, 0);
    check(32'(ch_intr_flags[aj[4:0]]), 32'(pass));
    check(32'(ch_err_flags[aj[4:0]]), 32'(pass));
    check(32'(ch_intr_flags[aj[4:0] + 5'h1]), 32'h1);
    check(n_mclr, 32'(!pass && k == K_MCLR && out));
    check(n_rclr, 32'(!pass && k == K_MCLR && !out));
    if (!pass && k == K_MCLR) check(last_dev, 32'(aj[4:0]));
  endtask
  task automatic errx(input logic m, input int hold);
    logic [23:0] pa;
    pa = 24'($urandom);
    pipe_idle <= 1'b0;
    clr();
    issue({OP_ERR_EXIT, 9'($urandom)}, m, pa, 24'($urandom), 24'($urandom));
    instr_valid <= 1'b0;
    rd(REG_STATUS, 32'h1);
    repeat (hold) @(posedge clk);
    pipe_idle <= 1'b1;
    await(n_done, 1);
    check(32'(xchg_pa), 32'(24'(pa + PARCEL_STEP)));
    rd(REG_SAVED_PA, 32'(24'(pa + PARCEL_STEP)));
    check(n_errf, 32'(!m));
    check(n_rise, 1);
    check(n_bad, 0);
    check(last_xa, 32'(xa_m));
    check(32'(instr_ready), 32'h1);
  endtask

  // main sequence
  initial begin
    {instr_valid, monitor_mode, reg_wr, reg_rd, slow} = '0;
    {instr, instr_pa, aj_val, ak_val, reg_addr, reg_wdata} = '0;
    {chan_intr_set, chan_err_set, ack_delay} = '0;
    pipe_idle = 1'b1;
    rst = 1'b1;
    void'($urandom(32'hf9db425d));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'({instr_ready, xchg_req, ch_done}), 32'h4);
    check(ch_active | ch_intr_flags | ch_err_flags, 32'h0);
    rd(REG_STATUS, 32'h4);
    rd(REG_XA, 32'(XA_RESET));
    rd(REG_DIR, DIR_RESET);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h0);
    xa_m = 8'($urandom);
    wr(REG_XA, 32'(xa_m));
    rd(REG_XA, 32'(xa_m));
    $display("test registers done");
    base = 24'($urandom) & 24'h00FFF0;
    ln = 1 + ($urandom % 6);
    xfer(5'd2, base + 24'(ln), base, 1'b0, 1'b0);
    slow <= 1'b1;
    xfer(5'd25, 24'h0, 24'h0, 1'b1, 1'b0);
    xfer(5'(3 + $urandom % 22), 24'(1 + ln), 24'h0, 1'b0, 1'b1);
    slow <= 1'b0;
    $display("test transfers done");
    ctl(FIELD_ZERO, 3'h2, 1'b1, 1'b1, 1'b0, 24'd2);
    ctl(K_MCLR, 3'h4, 1'b1, 1'b1, 1'b0, 24'd25);
    ctl(K_MCLR, 3'h6, 1'b1, 1'b0, 1'b0, 24'd9);
    ctl(K_MCLR, 3'h2, 1'b0, 1'b1, 1'b1, 24'd7);
    ctl(K_MCLR, FIELD_ZERO, 1'b1, 1'b1, 1'b1, 24'd8);
    ctl(K_MCLR, 3'h3, 1'b1, 1'b1, 1'b1, 24'd1);
    ctl(K_MCLR, 3'h3, 1'b1, 1'b1, 1'b1, 24'd26);
    ctl(K_MCLR, 3'h3, 1'b1, 1'b1, 1'b1, 24'h000102);
    $display("test channel control done");
    ack_delay <= 4'h9;
    errx(1'b0, 3);
    ack_delay <= 4'h0;
    errx(1'b1, 0);
    $display("test error exit done");
    final_report();
  end
endmodule
`default_nettype wire
